// >>> rtl/pmtr_regs.sv
// Telemetry readout registers answering read commands by command code
`timescale 1ns/100ps
module pmtr_regs #(
  parameter int AVG_LOG = 4, // Power average over 2**AVG_LOG pairs
  // Maker string; the value is arbitrary
  parameter logic [23:0] MAKER_IDENTITY = 24'h58_595A
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire pmtr_pkg::pmtr_meas_type meas,
  input wire pmtr_pkg::pmtr_pair_type pair,
  input wire pmtr_pkg::pmtr_cmd_type cmd,
  output pmtr_pkg::pmtr_resp_type resp,
  output logic write_ignored
);

  // Refuse averaging depths the sum register cannot hold
  generate
    if (AVG_LOG < 0 || AVG_LOG > 8) begin : g_bad_avg
      $error("AVG_LOG must lie in 0..8");
    end
  endgenerate

  localparam int SUM_BITS = 24 + AVG_LOG;
  localparam logic [AVG_LOG:0] AVG_LAST = (AVG_LOG + 1)'((1 << AVG_LOG) - 1);

  // Averaged readings, stored at 12 bits only
  logic [11:0] vin_q;
  logic [11:0] vout_q;
  logic [11:0] iout_q;
  logic [11:0] temp_q;
  logic [15:0] power_q; // Averaged input power
  logic [15:0] power_d;

  // Power averaging state
  logic [SUM_BITS-1:0] psum_q; // Running sum of products
  logic [SUM_BITS-1:0] psum_d;
  logic [AVG_LOG:0] pcnt_q; // Products taken in this window
  logic [AVG_LOG:0] pcnt_d;
  logic [23:0] product; // One voltage times current sample
  logic [SUM_BITS-1:0] psum_next; // Sum including this product
  logic [23:0] pavg; // Window average at full width
  logic window_done;

  // Energy side
  logic [15:0] energy;
  logic [7:0] wrap_tally;
  logic [23:0] sample_tally;

  // Answer registers and their next values
  pmtr_pkg::pmtr_resp_type resp_q;
  pmtr_pkg::pmtr_resp_type resp_d;
  logic wr_ign_q;

  // Widen a 12-bit reading; the top nibble always reads zero
  function automatic logic [47:0] word12(input logic [11:0] v);
    word12 = {36'h0_0000_0000, v};
  endfunction

  // Product per sample pair; averaging comes afterwards
  assign product = pair.volt * pair.curr;
  assign psum_next = psum_q + SUM_BITS'(product);
  assign window_done = pair.valid && (pcnt_q == AVG_LAST);
  assign pavg = psum_next[SUM_BITS-1:AVG_LOG];
  assign psum_d = !pair.valid ? psum_q :
                  window_done ? '0 : psum_next;
  assign pcnt_d = !pair.valid ? pcnt_q :
                  window_done ? '0 : pcnt_q + 1'b1;
  // Readout changes only when a full window closes
  assign power_d = window_done ? pavg[23:8] : power_q;

  // Each product feeds the energy accumulator as one sample
  pmtr_energy u_energy (
    .clk(clk),
    .rst_b(rst_b),
    .add_en(pair.valid),
    .add_val(product[23:8]),
    .energy(energy),
    .wrap_tally(wrap_tally),
    .sample_tally(sample_tally)
  );

  // Readings load from the sequencer strobes only, never from writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vin_q <= pmtr_pkg::READING_RESET;
      vout_q <= pmtr_pkg::READING_RESET;
      iout_q <= pmtr_pkg::READING_RESET;
      temp_q <= pmtr_pkg::READING_RESET;
    end else begin
      if (meas.vin_upd) begin
        vin_q <= meas.vin;
      end
      if (meas.vout_upd) begin
        vout_q <= meas.vout;
      end
      if (meas.iout_upd) begin
        iout_q <= meas.iout;
      end
      if (meas.temp_upd) begin
        temp_q <= meas.temp;
      end
    end
  end

  // Power window state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      psum_q <= '0;
      pcnt_q <= '0;
      power_q <= pmtr_pkg::POWER_RESET;
    end else begin
      psum_q <= psum_d;
      pcnt_q <= pcnt_d;
      power_q <= power_d;
    end
  end

  // Command decode; writes share the decode but select nothing
  wire hit_energy = cmd.code == pmtr_pkg::CMD_ENERGY_SNAPSHOT;
  wire hit_vin = cmd.code == pmtr_pkg::CMD_INPUT_VOLTAGE;
  wire hit_vout = cmd.code == pmtr_pkg::CMD_OUTPUT_VOLTAGE;
  wire hit_iout = cmd.code == pmtr_pkg::CMD_OUTPUT_CURRENT;
  wire hit_temp = cmd.code == pmtr_pkg::CMD_TEMPERATURE;
  wire hit_power = cmd.code == pmtr_pkg::CMD_INPUT_POWER;
  wire hit_rev = cmd.code == pmtr_pkg::CMD_BUS_REVISION;
  wire hit_maker = cmd.code == pmtr_pkg::CMD_MAKER_IDENTITY;
  // Any of the eight table codes; everything else answers unmapped
  wire hit_any = hit_energy || hit_vin || hit_vout || hit_iout ||
                 hit_temp || hit_power || hit_rev || hit_maker;

  // Three energy fields taken from one set of flops in one cycle
  wire [47:0] snap_word = {sample_tally, wrap_tally, energy};
  wire [47:0] rev_word = {40'h00_0000_0000,
                          pmtr_pkg::PART_ONE_REV_NIBBLE,
                          pmtr_pkg::PART_TWO_REV_NIBBLE};
  wire [47:0] maker_word = {24'h00_0000, MAKER_IDENTITY};

  // Select the answer for a read; anything else answers unmapped
  always_comb begin
    resp_d = '0;
    resp_d.valid = cmd.rd;
    if (!cmd.rd) begin
      resp_d.valid = 1'b0;
    end else if (hit_energy) begin
      resp_d.data = snap_word;
      resp_d.len = pmtr_pkg::LEN_ENERGY;
    end else if (hit_vin) begin
      resp_d.data = word12(vin_q);
      resp_d.len = pmtr_pkg::LEN_WORD;
    end else if (hit_vout) begin
      resp_d.data = word12(vout_q);
      resp_d.len = pmtr_pkg::LEN_WORD;
    end else if (hit_iout) begin
      resp_d.data = word12(iout_q);
      resp_d.len = pmtr_pkg::LEN_WORD;
    end else if (hit_temp) begin
      resp_d.data = word12(temp_q);
      resp_d.len = pmtr_pkg::LEN_WORD;
    end else if (hit_power) begin
      resp_d.data = {32'h0000_0000, power_q};
      resp_d.len = pmtr_pkg::LEN_WORD;
    end else if (hit_rev) begin
      resp_d.data = rev_word;
      resp_d.len = pmtr_pkg::LEN_BYTE;
    end else if (hit_maker) begin
      resp_d.data = maker_word;
      resp_d.len = pmtr_pkg::LEN_MAKER;
    end else begin
      resp_d.unmapped = 1'b1;
      resp_d.len = pmtr_pkg::LEN_NONE;
    end
  end

  // Answer registers; a write only raises the ignored pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp_q <= '0;
      wr_ign_q <= 1'b0;
    end else begin
      resp_q <= resp_d;
      wr_ign_q <= cmd.wr;
    end
  end

  assign resp = resp_q;
  assign write_ignored = wr_ign_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_snap_fields: assert property (
    cmd.rd && hit_energy |=>
      resp_q.data[47:24] == $past(sample_tally) &&
      resp_q.data[23:16] == $past(wrap_tally) &&
      resp_q.data[15:0] == $past(energy) && resp_q.len == 3'h6)
    else $error("energy snapshot fields wrong");

  chk_snap_reset: assert property (
    $rose(rst_b) ##0 cmd.rd && hit_energy |=>
      resp_q.data == 48'h0000_0000_0000)
    else $error("energy snapshot not zero after reset");

  chk_vin_read: assert property (
    cmd.rd && hit_vin |=> resp_q.valid &&
      resp_q.data[15:12] == 4'h0 && resp_q.data[11:0] == $past(vin_q))
    else $error("input voltage readout wrong");

  chk_vout_read: assert property (
    cmd.rd && hit_vout |=>
      resp_q.data == {36'h0_0000_0000, $past(vout_q)})
    else $error("output voltage readout wrong");

  chk_iout_read: assert property (
    cmd.rd && hit_iout |=>
      resp_q.data[15:12] == 4'h0 && resp_q.data[11:0] == $past(iout_q))
    else $error("output current readout wrong");

  chk_temp_read: assert property (
    meas.temp_upd ##1 cmd.rd && hit_temp && !meas.temp_upd |=>
      resp_q.data[11:0] == $past(meas.temp, 2) &&
      resp_q.data[15:12] == 4'h0)
    else $error("temperature readout wrong");

  chk_power_window: assert property (
    !window_done |=> $stable(power_q))
    else $error("power readout moved mid window");

  chk_power_avg: assert property (
    window_done |=> power_q == $past(pavg[23:8]) && pcnt_q == '0)
    else $error("power average not loaded at window end");

  chk_rev_value: assert property (
    cmd.rd && hit_rev |=> resp_q.data[7:0] == 8'h22 &&
      resp_q.len == 3'h1)
    else $error("bus revision wrong");

  chk_maker_fixed: assert property (
    cmd.rd && hit_maker |=> resp_q.data[23:0] == MAKER_IDENTITY &&
      resp_q.data[47:24] == 24'h00_0000)
    else $error("maker identity wrong");

  chk_write_ignored: assert property (
    cmd.wr && !cmd.rd && !meas.vin_upd && !window_done |=>
      $stable(vin_q) && $stable(power_q) && write_ignored &&
      !resp_q.valid)
    else $error("write changed a readout register");

  chk_read_latency: assert property (
    cmd.rd |=> resp_q.valid ##1 (resp_q.valid == $past(cmd.rd)))
    else $error("read answer not one cycle later");

  // Without a read the answer port stays all zero
  chk_idle_quiet: assert property (
    !cmd.rd |=> resp_q == '0)
    else $error("answer port active without a read");

  // Codes outside the table answer unmapped and carry no data
  chk_unmapped_code: assert property (
    cmd.rd && !hit_any |=> resp_q.valid && resp_q.unmapped &&
      resp_q.len == pmtr_pkg::LEN_NONE &&
      resp_q.data == 48'h0000_0000_0000)
    else $error("unknown code not answered as unmapped");

  // Table codes never answer unmapped
  chk_table_mapped: assert property (
    cmd.rd && hit_any |=> resp_q.valid && !resp_q.unmapped)
    else $error("table code answered as unmapped");

  // Power readout returns the stored average, upper bits unused
  chk_power_read: assert property (
    cmd.rd && hit_power |=> resp_q.len == pmtr_pkg::LEN_WORD &&
      resp_q.data == {32'h0000_0000, $past(power_q)})
    else $error("input power readout wrong");

  // The four 12-bit readings answer as two-byte words
  chk_word_len: assert property (
    cmd.rd && (hit_vin || hit_vout || hit_iout || hit_temp) |=>
      resp_q.len == pmtr_pkg::LEN_WORD)
    else $error("reading answered with wrong length");

  // A strobe loads its reading on the same edge
  chk_vin_load: assert property (
    meas.vin_upd |=> vin_q == $past(meas.vin))
    else $error("input voltage strobe not taken");

  chk_vout_load: assert property (
    meas.vout_upd |=> vout_q == $past(meas.vout))
    else $error("output voltage strobe not taken");

  chk_iout_load: assert property (
    meas.iout_upd |=> iout_q == $past(meas.iout))
    else $error("output current strobe not taken");

  // Without a strobe a reading holds, whatever the host sends
  chk_temp_hold: assert property (
    !meas.temp_upd |=> $stable(temp_q))
    else $error("temperature reading moved without a strobe");

  chk_vout_hold: assert property (
    !meas.vout_upd |=> $stable(vout_q))
    else $error("output voltage moved without a strobe");

  // The window counter never passes the last product of a window
  chk_window_bound: assert property (
    pcnt_q <= AVG_LAST)
    else $error("power window count out of range");

  // Every write, alone or with a read, raises the ignored pulse
  chk_write_pulse: assert property (
    cmd.wr |=> write_ignored)
    else $error("write not flagged as ignored");

  chk_write_quiet: assert property (
    !cmd.wr |=> !write_ignored)
    else $error("ignored pulse without a write");

  // The maker string answers as three bytes
  chk_maker_len: assert property (
    cmd.rd && hit_maker |=> resp_q.len == pmtr_pkg::LEN_MAKER)
    else $error("maker identity length wrong");

endmodule

// >>> rtl/pmtr_pkg.sv
// Package with command codes, field layouts and carriers for telemetry
package pmtr_pkg;

  // Command codes of the readout registers
  localparam logic [7:0] CMD_ENERGY_SNAPSHOT = 8'h86;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8C;
  localparam logic [7:0] CMD_TEMPERATURE = 8'h8D;
  localparam logic [7:0] CMD_INPUT_POWER = 8'h97;
  localparam logic [7:0] CMD_BUS_REVISION = 8'h98;
  localparam logic [7:0] CMD_MAKER_IDENTITY = 8'h99;

  // Byte counts of each answer
  localparam logic [2:0] LEN_ENERGY = 3'h6;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_MAKER = 3'h3;
  localparam logic [2:0] LEN_NONE = 3'h0;

  // Field positions inside the energy snapshot
  localparam int SNAP_COUNT_LSB = 24;
  localparam int SNAP_WRAP_LSB = 16;
  localparam int SNAP_ENERGY_LSB = 0;

  // Reading width and where the truncated energy starts in the accumulator
  localparam int READING_BITS = 12;
  localparam int ENERGY_TRUNC_LSB = 8;

  // Reset values
  localparam logic [47:0] ENERGY_SNAPSHOT_RESET = 48'h0000_0000_0000;
  localparam logic [11:0] READING_RESET = 12'h000;
  localparam logic [15:0] POWER_RESET = 16'h0000;
  localparam logic [23:0] ACCUM_RESET = 24'h00_0000;
  localparam logic [7:0] WRAP_RESET = 8'h00;

  // Revision nibbles: code 0010 stands for revision 1.2
  localparam logic [3:0] PART_ONE_REV_NIBBLE = 4'h2;
  localparam logic [3:0] PART_TWO_REV_NIBBLE = 4'h2;
  localparam logic [7:0] BUS_REVISION_RESET = 8'h22;

  // Averaged readings from the converter sequencer
  typedef struct packed {
    logic vin_upd;
    logic [11:0] vin;
    logic vout_upd;
    logic [11:0] vout;
    logic iout_upd;
    logic [11:0] iout;
    logic temp_upd;
    logic [11:0] temp;
  } pmtr_meas_type;

  // One raw voltage and current sample pair for power
  typedef struct packed {
    logic valid;
    logic [11:0] volt;
    logic [11:0] curr;
  } pmtr_pair_type;

  // Command from the bus protocol engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] code;
  } pmtr_cmd_type;

  // Answer to a read command
  typedef struct packed {
    logic valid;
    logic unmapped;
    logic [2:0] len;
    logic [47:0] data;
  } pmtr_resp_type;

endpackage

// >>> rtl/pmtr_energy.sv
// Energy accumulator with wrap and sample tallies
`timescale 1ns/100ps
module pmtr_energy (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic add_en,
  input wire logic [15:0] add_val,
  output logic [15:0] energy,
  output logic [7:0] wrap_tally,
  output logic [23:0] sample_tally
);

  logic [23:0] accum_q; // Internal full-width accumulator
  logic [23:0] accum_d;
  logic [7:0] wrap_q;
  logic [7:0] wrap_d;
  logic [23:0] count_q;
  logic [23:0] count_d;
  logic [24:0] sum; // One bit wider to see the carry
  logic wraps; // Upper 16 bits pass 0x7FFF

  // Bit 23 set means the returned field went past 0x7FFF
  assign sum = {1'b0, accum_q} + {9'h000, add_val};
  assign wraps = add_en && sum[23];
  // Dropping bit 23 folds the field back to 0x0000 upward
  assign accum_d = add_en ? {1'b0, sum[22:0]} : accum_q;
  assign wrap_d = wraps ? wrap_q + 8'h01 : wrap_q;
  assign count_d = add_en ? count_q + 24'h00_0001 : count_q;

  // All three move on the same edge, so any read is consistent
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accum_q <= pmtr_pkg::ACCUM_RESET;
      wrap_q <= pmtr_pkg::WRAP_RESET;
      count_q <= pmtr_pkg::ACCUM_RESET;
    end else begin
      accum_q <= accum_d;
      wrap_q <= wrap_d;
      count_q <= count_d;
    end
  end

  // Only the upper 16 bits leave the block
  assign energy = accum_q[23:pmtr_pkg::ENERGY_TRUNC_LSB];
  assign wrap_tally = wrap_q;
  assign sample_tally = count_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_wrap_counts_up: assert property (
    add_en && sum[23] |=> wrap_q == $past(wrap_q) + 8'h01 &&
      accum_q[23:8] <= 16'h00FF)
    else $error("wrap tally did not follow an energy wrap");

  chk_no_false_wrap: assert property (
    !(add_en && sum[23]) |=> $stable(wrap_q))
    else $error("wrap tally moved without a wrap");

  chk_energy_bound: assert property (
    accum_q[23] == 1'b0)
    else $error("returned energy exceeded 0x7FFF");

  chk_sample_count: assert property (
    add_en |=> count_q == $past(count_q) + 24'h00_0001)
    else $error("sample tally missed a power sample");

  chk_reset_zero: assert property (
    $rose(rst_b) |-> accum_q == 24'h00_0000 && wrap_q == 8'h00 &&
      count_q == 24'h00_0000)
    else $error("energy fields not zero after reset");

endmodule

// >>> testbench/pmtr_host_model.sv
// Host-side model that issues commands to the telemetry readout block
`timescale 1ns/100ps
module pmtr_host_model (
  output pmtr_pkg::pmtr_cmd_type cmd
);
  logic [7:0] last_code = 8'h00; // Code of the most recent command
  // Idle from time zero
  initial cmd = '{rd: 1'b0, wr: 1'b0, code: 8'hFF};
  // Called just after a rising edge; the command stands for one cycle
  task automatic drive(input logic rd, input logic wr, input logic [7:0] c);
    if (rd || wr) begin
      cmd = '{rd: rd, wr: wr, code: c};
      last_code = c;
    end else begin
      // Idle code lines show the inverse, so nothing stale can match
      cmd = '{rd: 1'b0, wr: 1'b0, code: ~last_code};
    end
  endtask
endmodule

// >>> testbench/pmtr_regs_bench.sv
// Self-checking bench for the telemetry readout registers
`timescale 1ns/100ps
module pmtr_regs_bench;
  localparam int AVG = 1; // Short power window keeps the run brief
  localparam logic [23:0] MAKER = 24'h4A_4B4C; // Arbitrary maker string
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pmtr_pkg::pmtr_meas_type meas = '0;
  pmtr_pkg::pmtr_pair_type pair = '0;
  pmtr_pkg::pmtr_cmd_type cmd;
  pmtr_pkg::pmtr_resp_type resp;
  logic write_ignored;
  logic wr_seen = 1'b0; // Write taken at the last edge
  int err_total = 0;
  int checks_done = 0;
  pmtr_pkg::pmtr_resp_type exp_q[$]; // Answers still owed by the block
  // Reference state of the readings and tallies
  logic [11:0] rd_v[4];
  logic [23:0] acc_m;
  logic [7:0] wrap_m;
  logic [23:0] cnt_m;
  logic [15:0] pwr_m;
  logic [31:0] sum_m;
  int win_m;
  logic [7:0] codes[8];

  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;

  pmtr_regs #(.AVG_LOG(AVG), .MAKER_IDENTITY(MAKER)) dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .meas(meas),
    .pair(pair),
    .cmd(cmd),
    .resp(resp),
    .write_ignored(write_ignored)
  );
  pmtr_host_model host_u (.cmd(cmd));

  // Compare and count; unknowns never pass
  task automatic check(input logic [52:0] seen, input logic [52:0] want,
                       input string what);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen,
               want);
    end
  endtask

  // Everything back to its reset state
  task automatic reset_model();
    rd_v = '{default: 12'h000};
    acc_m = '0;
    wrap_m = '0;
    cnt_m = '0;
    pwr_m = '0;
    sum_m = '0;
    win_m = 0;
  endtask

  // Build one valid answer
  function automatic pmtr_pkg::pmtr_resp_type mk(input logic [2:0] n,
                                                  input logic [47:0] d);
    return '{valid: 1'b1, unmapped: 1'b0, len: n, data: d};
  endfunction

  // Answer the block owes for a read of code c
  function automatic pmtr_pkg::pmtr_resp_type answer(input logic [7:0] c);
    case (c)
      pmtr_pkg::CMD_ENERGY_SNAPSHOT:
        return mk(3'h6, {cnt_m, wrap_m, acc_m[23:8]});
      pmtr_pkg::CMD_INPUT_VOLTAGE: return mk(3'h2, {36'h0, rd_v[0]});
      pmtr_pkg::CMD_OUTPUT_VOLTAGE: return mk(3'h2, {36'h0, rd_v[1]});
      pmtr_pkg::CMD_OUTPUT_CURRENT: return mk(3'h2, {36'h0, rd_v[2]});
      pmtr_pkg::CMD_TEMPERATURE: return mk(3'h2, {36'h0, rd_v[3]});
      pmtr_pkg::CMD_INPUT_POWER: return mk(3'h2, {32'h0, pwr_m});
      pmtr_pkg::CMD_BUS_REVISION: return mk(3'h1, 48'h22);
      pmtr_pkg::CMD_MAKER_IDENTITY: return mk(3'h3, {24'h0, MAKER});
      // Codes outside the table answer as unmapped, no data
      default: return '{valid: 1'b1, unmapped: 1'b1, len: 3'h0, data: '0};
    endcase
  endfunction

  // Drive one cycle of inputs, note the answer, then advance the model
  task automatic step(input logic rd, input logic wr, input logic [7:0] c,
                      input pmtr_pkg::pmtr_meas_type m,
                      input pmtr_pkg::pmtr_pair_type p);
    logic [23:0] prod;
    host_u.drive(rd, wr, c);
    meas = m;
    pair = p;
    // Read in a strobe cycle still sees the old value
    if (rd) exp_q.push_back(answer(c));
    if (m.vin_upd) rd_v[0] = m.vin;
    if (m.vout_upd) rd_v[1] = m.vout;
    if (m.iout_upd) rd_v[2] = m.iout;
    if (m.temp_upd) rd_v[3] = m.temp;
    if (p.valid) begin
      prod = p.volt * p.curr;
      acc_m = acc_m + {8'h00, prod[23:8]};
      // Field passed 0x7FFF: wrap to a low value and count it
      if (acc_m[23]) begin
        acc_m[23] = 1'b0;
        wrap_m++;
      end
      cnt_m++;
      sum_m = sum_m + prod;
      win_m++;
      // Average of products, not product of averages
      if (win_m == 2 ** AVG) begin
        pwr_m = 16'(sum_m >> (AVG + 8));
        sum_m = '0;
        win_m = 0;
      end
    end
    @(posedge clk);
    #1;
  endtask

  // Read all eight registers back to back
  task automatic read_all();
    for (int i = 0; i < 8; i++) step(1'b1, 1'b0, codes[i], '0, '0);
  endtask

  // Watch answers mid-cycle, when they have settled
  always @(negedge clk) begin
    if (resp.valid === 1'b1 && exp_q.size() > 0)
      check(resp, exp_q.pop_front(), "answer");
    else
      check(resp, '0, "idle answer");
    check({52'h0, write_ignored}, {52'h0, wr_seen}, "write flag");
  end
  // Remember whether a write was taken at this edge
  always @(posedge clk) wr_seen <= cmd.wr & rst_b;

  task automatic tally_and_finish();
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH at %0t: answers missing", $time);
    end
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hang short well after the tests should be over
  initial begin
    #(25 * 4000);
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [31:0] k;
    pmtr_pkg::pmtr_meas_type m;
    pmtr_pkg::pmtr_pair_type p;
    void'($urandom(32'h7d3bb469));
    codes = '{pmtr_pkg::CMD_ENERGY_SNAPSHOT, pmtr_pkg::CMD_INPUT_VOLTAGE,
      pmtr_pkg::CMD_OUTPUT_VOLTAGE, pmtr_pkg::CMD_OUTPUT_CURRENT,
      pmtr_pkg::CMD_TEMPERATURE, pmtr_pkg::CMD_INPUT_POWER,
      pmtr_pkg::CMD_BUS_REVISION, pmtr_pkg::CMD_MAKER_IDENTITY};
    reset_model();
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // Reset values, then two codes outside the table
    read_all();
    step(1'b1, 1'b0, 8'h87, '0, '0);
    step(1'b1, 1'b0, 8'h9A, '0, '0);
    $display("test reset values done");
    // Random strobes, pairs, reads and writes every cycle
    for (int i = 0; i < 400; i++) begin
      k = $urandom();
      m = 52'({$urandom(), $urandom()});
      p = 25'($urandom());
      step(k[0], k[1] & k[2], (k[8:6] == 3'h0) ? {4'hA, k[12:9]} :
           codes[k[5:3]], m, p);
    end
    $display("test random traffic done");
    // Large pairs wrap the energy field; snapshot read every cycle
    for (int i = 0; i < 300; i++) begin
      p = '{valid: 1'b1, volt: 12'hF00 | 12'($urandom()),
            curr: 12'hF00 | 12'($urandom())};
      step(1'b1, 1'b0, pmtr_pkg::CMD_ENERGY_SNAPSHOT, '0, p);
    end
    $display("test energy wrap done");
    // Writes to every code change nothing
    for (int i = 0; i < 8; i++) step(1'b0, 1'b1, codes[i], '0, '0);
    read_all();
    $display("test ignored writes done");
    // Reset in mid-run clears readings and tallies
    step(1'b0, 1'b0, 8'h00, '0, '0);
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    reset_model();
    read_all();
    step(1'b0, 1'b0, 8'h00, '0, '0);
    step(1'b0, 1'b0, 8'h00, '0, '0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
